/* io_sample_generator.sv */
/*
  I/O sample generator: periodic, change-detect and forced reports over an
  AHB-Lite register slave. Digital lines, awake level and supply reading come
  from outside the clock domain and are synchronised here; the report and
  response strobes go to a framing stage outside this block.
*/
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module io_sample_generator #(
  parameter int CYCLES_PER_MS = io_sample_pkg::CYCLES_PER_MS
) (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [14:0] digital_line_in,
  input  wire logic        awake_in,
  input  wire logic [15:0] supply_mv_in,
  output logic             report_valid_out,
  output logic      [1:0]  report_kind_out,
  output logic      [63:0] report_dest_out,
  output logic      [14:0] report_lines_out,
  output logic      [7:0]  report_adc_mask_out,
  output logic      [15:0] report_supply_out,
  output logic             force_error_out,
  output logic      [1:0]  adc_reference_select_out
);

  typedef struct packed {
    logic [14:0] line_s1;
    logic [14:0] line_s2;
    logic        awake_s1;
    logic        awake_s2;
    logic [15:0] supply_s1;
    logic [15:0] supply_s2;
    logic [31:0] dest_address_high;
    logic [31:0] dest_address_low;
    logic [15:0] sample_interval;
    logic [14:0] change_detect_mask;
    logic [1:0]  adc_reference_select;
    logic [15:0] supply_threshold;
    logic [14:0] line_used;
    logic [3:0]  adc_enable;
    logic [14:0] history;
    logic        history_valid;
    logic [15:0] ms_count;
    logic        ap_write;
    logic        ap_read;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
    logic        report_valid;
    logic [1:0]  report_kind;
    logic [63:0] report_dest;
    logic [14:0] report_lines;
    logic [7:0]  report_adc_mask;
    logic [15:0] report_supply;
    logic        force_error;
    logic [15:0] report_count;
    logic        error_seen;
  } gen_state_t;

  gen_state_t state;
  gen_state_t next_state;
  logic       ms_tick;

  ms_tick_gen #(
    .CYCLES (CYCLES_PER_MS)
  ) u_tick (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .tick_out (ms_tick)
  );

  function automatic logic [31:0] read_reg(input gen_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      io_sample_pkg::OFF_DEST_HIGH:    v = s.dest_address_high;
      io_sample_pkg::OFF_DEST_LOW:     v = s.dest_address_low;
      io_sample_pkg::OFF_SAMPLE_INT:   v = {16'h0000, s.sample_interval};
      io_sample_pkg::OFF_CHANGE_MASK:  v = {17'h00000, s.change_detect_mask};
      io_sample_pkg::OFF_ADC_REF:      v = {30'h0000_0000, s.adc_reference_select};
      io_sample_pkg::OFF_SUPPLY_THR:   v = {16'h0000, s.supply_threshold};
      io_sample_pkg::OFF_LINE_CFG:     v = {17'h00000, s.line_used};
      io_sample_pkg::OFF_ADC_EN:       v = {28'h000_0000, s.adc_enable};
      io_sample_pkg::OFF_STATUS:       v = {s.report_count, 14'h0000, s.error_seen,
                                            s.awake_s2};
      io_sample_pkg::OFF_REPORT_LINES: v = {17'h00000, s.report_lines};
      io_sample_pkg::OFF_REPORT_INFO:  v = {s.report_supply, s.report_adc_mask, 6'h00,
                                            s.report_kind};
      default:                         v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic        valid_config;
  logic        supply_append;
  logic [14:0] changed;
  logic        periodic_due;
  logic        change_due;
  logic        force_cmd;
  logic        force_remote;
  logic [7:0]  adc_mask;

  always_comb begin
    valid_config = |state.line_used;
    if (state.supply_threshold == 16'h0000) begin
      supply_append = 1'b0;
    end else if (state.supply_threshold == 16'h0001) begin
      supply_append = 1'b1;
    end else begin
      supply_append = state.supply_s2 <= state.supply_threshold;
    end
    adc_mask = {4'h0, state.adc_enable};
    adc_mask[io_sample_pkg::SUPPLY_MASK_BIT] = supply_append;
    changed = (state.line_s2 ^ state.history) & state.change_detect_mask;
    change_due = state.awake_s2 && state.history_valid && (|changed) && valid_config;
    periodic_due = (state.sample_interval != 16'h0000) && ms_tick &&
                   (state.ms_count + 16'h0001 >= state.sample_interval) && valid_config;
    force_cmd = state.ap_write && (state.ap_addr == io_sample_pkg::OFF_COMMAND) &&
                hwdata_in[io_sample_pkg::CMD_FORCE_BIT];
    force_remote = hwdata_in[io_sample_pkg::CMD_REMOTE_BIT];
  end

  always_comb begin
    next_state = state;
    next_state.line_s1   = digital_line_in;
    next_state.line_s2   = state.line_s1;
    next_state.awake_s1  = awake_in;
    next_state.awake_s2  = state.awake_s1;
    next_state.supply_s1 = supply_mv_in;
    next_state.supply_s2 = state.supply_s1;
    next_state.report_valid = 1'b0;
    next_state.force_error  = 1'b0;

    // data phase of a write
    if (state.ap_write) begin
      case (state.ap_addr)
        io_sample_pkg::OFF_DEST_HIGH:   next_state.dest_address_high = hwdata_in;
        io_sample_pkg::OFF_DEST_LOW:    next_state.dest_address_low  = hwdata_in;
        io_sample_pkg::OFF_SAMPLE_INT:  next_state.sample_interval   = hwdata_in[15:0];
        io_sample_pkg::OFF_CHANGE_MASK: next_state.change_detect_mask = hwdata_in[14:0];
        io_sample_pkg::OFF_ADC_REF: begin
          if (hwdata_in[1:0] != 2'h3) begin
            next_state.adc_reference_select = hwdata_in[1:0];
          end
        end
        io_sample_pkg::OFF_SUPPLY_THR:  next_state.supply_threshold = hwdata_in[15:0];
        io_sample_pkg::OFF_LINE_CFG:    next_state.line_used        = hwdata_in[14:0];
        io_sample_pkg::OFF_ADC_EN:      next_state.adc_enable       = hwdata_in[3:0];
        io_sample_pkg::OFF_STATUS:      next_state.error_seen       = 1'b0;
        default: begin
        end
      endcase
    end

    // address phase capture, zero wait states
    next_state.ap_write = hsel_in && hready_in && htrans_in[1] && hwrite_in;
    next_state.ap_read  = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
    next_state.ap_addr  = haddr_in[7:0];
    next_state.rdata    = read_reg(next_state, haddr_in[7:0]);

    // interval reload on write or expiry
    if (state.ap_write && state.ap_addr == io_sample_pkg::OFF_SAMPLE_INT) begin
      next_state.ms_count = 16'h0000;
    end else if (ms_tick) begin
      if (state.ms_count + 16'h0001 >= state.sample_interval) begin
        next_state.ms_count = 16'h0000;
      end else begin
        next_state.ms_count = state.ms_count + 16'h0001;
      end
    end

    if (!state.awake_s2) begin
      next_state.history_valid = 1'b0;
    end else begin
      next_state.history       = state.line_s2;
      next_state.history_valid = 1'b1;
    end

    // force first, then change, then periodic
    if (force_cmd && !valid_config) begin
      next_state.force_error = 1'b1;
      next_state.error_seen  = 1'b1;
    end else if (force_cmd || change_due || periodic_due) begin
      next_state.report_valid = 1'b1;
      if (force_cmd) begin
        next_state.report_kind = force_remote ? io_sample_pkg::KIND_REMOTE
                                              : io_sample_pkg::KIND_LOCAL;
      end else if (change_due) begin
        next_state.report_kind = io_sample_pkg::KIND_CHANGE;
      end else begin
        next_state.report_kind = io_sample_pkg::KIND_PERIODIC;
      end
      next_state.report_dest     = {state.dest_address_high, state.dest_address_low};
      next_state.report_lines    = state.line_s2;
      next_state.report_adc_mask = adc_mask;
      next_state.report_supply   = supply_append ? state.supply_s2 : 16'h0000;
      next_state.report_count    = state.report_count + 16'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign hrdata_out               = state.rdata;
  assign hreadyout_out            = 1'b1;
  assign hresp_out                = 1'b0;
  assign report_valid_out         = state.report_valid;
  assign report_kind_out          = state.report_kind;
  assign report_dest_out          = state.report_dest;
  assign report_lines_out         = state.report_lines;
  assign report_adc_mask_out      = state.report_adc_mask;
  assign report_supply_out        = state.report_supply;
  assign force_error_out          = state.force_error;
  assign adc_reference_select_out = state.adc_reference_select;

  property p_no_report_unconfigured;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state.line_used == 15'h0000) |=> !state.report_valid;
  endproperty
  a_no_report_unconfigured: assert property (p_no_report_unconfigured)
    else $error("report made with no configured line");

  property p_dest_pair;
    @(posedge clock_in) disable iff (!rst_n_in)
      state.report_valid |->
        state.report_dest == {$past(state.dest_address_high), $past(state.dest_address_low)};
  endproperty
  a_dest_pair: assert property (p_dest_pair)
    else $error("report destination mismatch");

  property p_force_error;
    @(posedge clock_in) disable iff (!rst_n_in)
      (force_cmd && !valid_config) |=> state.force_error && !state.report_valid;
  endproperty
  a_force_error: assert property (p_force_error)
    else $error("force without lines not refused");

  property p_force_report;
    @(posedge clock_in) disable iff (!rst_n_in)
      (force_cmd && valid_config) |=> state.report_valid && state.report_kind[1];
  endproperty
  a_force_report: assert property (p_force_report)
    else $error("force did not report");

  property p_change_report;
    @(posedge clock_in) disable iff (!rst_n_in)
      (change_due && !force_cmd) |=> state.report_valid &&
        state.report_kind == io_sample_pkg::KIND_CHANGE;
  endproperty
  a_change_report: assert property (p_change_report)
    else $error("change did not report");

  property p_asleep_no_change;
    @(posedge clock_in) disable iff (!rst_n_in)
      !state.awake_s2 |-> !change_due ##1 !change_due;
  endproperty
  a_asleep_no_change: assert property (p_asleep_no_change)
    else $error("change seen while asleep");

  property p_supply_zero;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state.report_valid && $past(state.supply_threshold) == 16'h0000) |->
        !state.report_adc_mask[io_sample_pkg::SUPPLY_MASK_BIT];
  endproperty
  a_supply_zero: assert property (p_supply_zero)
    else $error("supply appended with zero threshold");

  property p_supply_flag;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state.report_valid && $past(state.supply_threshold) > 16'h0001) |->
        state.report_adc_mask[io_sample_pkg::SUPPLY_MASK_BIT] ==
        ($past(state.supply_s2) <= $past(state.supply_threshold));
  endproperty
  a_supply_flag: assert property (p_supply_flag)
    else $error("supply flag wrong");

  property p_periodic_off;
    @(posedge clock_in) disable iff (!rst_n_in)
      (state.sample_interval == 16'h0000) |-> !periodic_due;
  endproperty
  a_periodic_off: assert property (p_periodic_off)
    else $error("periodic report with zero interval");

  c_periodic: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state.report_valid && state.report_kind == io_sample_pkg::KIND_PERIODIC);
  c_change: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state.report_valid && state.report_kind == io_sample_pkg::KIND_CHANGE);
  c_force_err: cover property (@(posedge clock_in) disable iff (!rst_n_in)
    state.force_error);

endmodule

/* io_sample_pkg.sv */
/*
  Package for the I/O sample generator: register offsets, field layouts,
  reset values, report kinds and timing constants.
  Assumes a 40 MHz system clock and an AHB-Lite register bus with 32-bit data.
*/
package io_sample_pkg;

  localparam int          LINE_COUNT        = 15;
  localparam int          ADC_COUNT         = 4;

  // register byte offsets
  localparam logic [7:0]  OFF_DEST_HIGH     = 8'h00;
  localparam logic [7:0]  OFF_DEST_LOW      = 8'h04;
  localparam logic [7:0]  OFF_SAMPLE_INT    = 8'h08;
  localparam logic [7:0]  OFF_CHANGE_MASK   = 8'h0C;
  localparam logic [7:0]  OFF_ADC_REF       = 8'h10;
  localparam logic [7:0]  OFF_SUPPLY_THR    = 8'h14;
  localparam logic [7:0]  OFF_LINE_CFG      = 8'h18;
  localparam logic [7:0]  OFF_ADC_EN        = 8'h1C;
  localparam logic [7:0]  OFF_COMMAND       = 8'h20;
  localparam logic [7:0]  OFF_STATUS        = 8'h24;
  localparam logic [7:0]  OFF_REPORT_LINES  = 8'h28;
  localparam logic [7:0]  OFF_REPORT_INFO   = 8'h2C;

  // command register fields
  localparam int          CMD_FORCE_BIT     = 0;
  localparam int          CMD_REMOTE_BIT    = 1;

  // reset values
  localparam logic [15:0] SAMPLE_INT_RESET  = 16'h0000;
  localparam logic [14:0] CHANGE_MASK_RESET = 15'h0000;
  localparam logic [1:0]  ADC_REF_RESET     = 2'h0;
  localparam logic [15:0] SUPPLY_THR_RESET  = 16'h0000;
  localparam logic [31:0] DEST_RESET        = 32'h0000_0000;

  // adc reference codes
  localparam logic [1:0]  REF_1V25          = 2'h0;
  localparam logic [1:0]  REF_2V5           = 2'h1;
  localparam logic [1:0]  REF_SUPPLY        = 2'h2;

  // analog channel mask bit flagging supply reading
  localparam int          SUPPLY_MASK_BIT   = 7;

  // report kinds
  localparam logic [1:0]  KIND_PERIODIC     = 2'h0;
  localparam logic [1:0]  KIND_CHANGE       = 2'h1;
  localparam logic [1:0]  KIND_LOCAL        = 2'h2;
  localparam logic [1:0]  KIND_REMOTE       = 2'h3;

  // timing
  localparam int          CLOCK_HZ          = 40_000_000;
  localparam int          TICK_MS           = 1;
  localparam int          CYCLES_PER_MS     = CLOCK_HZ / 1000 * TICK_MS;
  localparam int          MS_COUNT_W        = 16;

endpackage

/* ms_tick_gen.sv */
/*
  Millisecond tick generator for the I/O sample generator.
  Assumes the 40 MHz clock from the package and an active-low async reset.
*/
`timescale 1ns/1ps
module ms_tick_gen #(
  parameter int CYCLES = io_sample_pkg::CYCLES_PER_MS
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } tick_state_t;

  tick_state_t state;
  tick_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 16'(CYCLES - 1)) begin
      next_state.count = 16'h0000;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;

endmodule

/* report_sink.sv */
/*
  Far-side model: the serial host or remote node that takes each report.
  Assumes registered one-cycle strobes whose fields are valid with the strobe.
*/
`timescale 1ns/1ps
module report_sink (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        report_valid_in,
  input  wire logic [1:0]  report_kind_in,
  input  wire logic [63:0] report_dest_in,
  input  wire logic [14:0] report_lines_in,
  input  wire logic [7:0]  report_adc_mask_in,
  input  wire logic [15:0] report_supply_in,
  input  wire logic        force_error_in,
  output logic      [15:0] report_count_out,
  output logic      [15:0] error_count_out,
  output logic      [1:0]  kind_out,
  output logic      [63:0] dest_out,
  output logic      [14:0] lines_out,
  output logic      [7:0]  adc_mask_out,
  output logic      [15:0] supply_out
);
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      report_count_out <= 16'h0000;
      error_count_out  <= 16'h0000;
      kind_out         <= 2'h0;
      dest_out         <= 64'h0;
      lines_out        <= 15'h0000;
      adc_mask_out     <= 8'h00;
      supply_out       <= 16'h0000;
    end else begin
      // take each report whole, as a receiver would
      if (report_valid_in) begin
        report_count_out <= report_count_out + 16'h0001;
        kind_out         <= report_kind_in;
        dest_out         <= report_dest_in;
        lines_out        <= report_lines_in;
        adc_mask_out     <= report_adc_mask_in;
        supply_out       <= report_supply_in;
      end
      if (force_error_in) begin
        error_count_out <= error_count_out + 16'h0001;
      end
    end
  end
endmodule

/* testbench.sv */
/*
  Self-checking bench for the I/O sample generator: register table loop,
  then reset, refusal, force, supply, change-detect and periodic cases.
  Assumes the design package, design files and report_sink compile first.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{io_sample_pkg::OFF_DEST_HIGH,   32'h1234_5678, 32'h1234_5678},
    '{io_sample_pkg::OFF_DEST_LOW,    32'h9ABC_DEF0, 32'h9ABC_DEF0},
    '{io_sample_pkg::OFF_SAMPLE_INT,  32'hFFFF_0032, 32'h0000_0032},
    '{io_sample_pkg::OFF_SAMPLE_INT,  32'h0000_0000, 32'h0000_0000},
    '{io_sample_pkg::OFF_CHANGE_MASK, 32'hFFFF_FFFF, 32'h0000_7FFF},
    '{io_sample_pkg::OFF_ADC_REF,     32'h0000_0001, 32'h0000_0001},
    '{io_sample_pkg::OFF_ADC_REF,     32'h0000_0002, 32'h0000_0002},
    '{io_sample_pkg::OFF_ADC_REF,     32'h0000_0003, 32'h0000_0002},
    '{io_sample_pkg::OFF_ADC_REF,     32'h0000_0000, 32'h0000_0000},
    '{8'h30,                          32'hFFFF_FFFF, 32'h0000_0000}
  };
  localparam logic [15:0] SUPPLY = 16'h0BB8;
  localparam logic [15:0] THR [4] = '{16'h0000, 16'h0001, 16'h0BB8, 16'h0BB7};
  localparam logic [3:0]  ADDS = 4'b0110;
  localparam int          MS_CYCLES = 10;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [14:0] lines    = 15'h0008;
  logic        awake    = 1'b1;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, rep_valid, force_err;
  logic [1:0]  rep_kind, adc_ref, last_kind;
  logic [63:0] rep_dest, last_dest;
  logic [14:0] rep_lines, last_lines;
  logic [7:0]  rep_mask, last_mask;
  logic [15:0] rep_supply, n_reports, n_errors, last_supply;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_exp = 0;
  int          cycles = 0;
  int          n_wait = 0;

  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  io_sample_generator #(.CYCLES_PER_MS(MS_CYCLES)) i_io_sample_generator (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .digital_line_in(lines), .awake_in(awake),
    .supply_mv_in(SUPPLY), .report_valid_out(rep_valid), .report_kind_out(rep_kind),
    .report_dest_out(rep_dest), .report_lines_out(rep_lines),
    .report_adc_mask_out(rep_mask), .report_supply_out(rep_supply),
    .force_error_out(force_err), .adc_reference_select_out(adc_ref));

  report_sink i_report_sink (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .report_valid_in(rep_valid),
    .report_kind_in(rep_kind), .report_dest_in(rep_dest), .report_lines_in(rep_lines),
    .report_adc_mask_in(rep_mask), .report_supply_in(rep_supply),
    .force_error_in(force_err), .report_count_out(n_reports),
    .error_count_out(n_errors), .kind_out(last_kind), .dest_out(last_dest),
    .lines_out(last_lines), .adc_mask_out(last_mask), .supply_out(last_supply));

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %0t %s: saw %0h want %0h", $time, what, seen, exp);
      n_fail++;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_in);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clock_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_report(output int n);
    n = 0;
    while (n_reports !== 16'(n_exp) && n < 1000) begin
      @(posedge clock_in);
      n++;
    end
  endtask

  task automatic expect_reports(input string what);
    for (int i = 0; i < 20 && n_reports !== 16'(n_exp); i++) @(posedge clock_in);
    repeat (3) @(posedge clock_in);
    check(n_reports, 16'(n_exp), what);
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].addr, ROWS[i].wdata);
      bus(1'b0, ROWS[i].addr, 32'h0);
      check(rd, ROWS[i].rdata, "register readback");
      check(hresp, 1'b0, "okay response");
      check(adc_ref, ROWS[i].rdata[1:0] & {2{ROWS[i].addr == 8'h10}}, "ref out");
    end
    $display("test registers done");
    bus(1'b1, io_sample_pkg::OFF_ADC_REF, 32'h2);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    check(adc_ref, io_sample_pkg::ADC_REF_RESET, "ref after reset");
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      check(rd, '0, "reset value");
    end
    $display("test reset done");
    bus(1'b1, io_sample_pkg::OFF_CHANGE_MASK, 32'h8);
    lines <= 15'h0000;
    expect_reports("no line configured");
    bus(1'b1, io_sample_pkg::OFF_COMMAND, 32'h1);
    expect_reports("force refused");
    check(n_errors, 16'h1, "force error");
    bus(1'b0, io_sample_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0003, "error flag set");
    bus(1'b1, io_sample_pkg::OFF_STATUS, 32'h0);
    bus(1'b0, io_sample_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h0000_0001, "error flag cleared");
    $display("test refusal done");
    bus(1'b1, io_sample_pkg::OFF_LINE_CFG, 32'h9);
    bus(1'b1, io_sample_pkg::OFF_ADC_EN, 32'hF);
    bus(1'b1, io_sample_pkg::OFF_DEST_HIGH, 32'hA5A5_0001);
    bus(1'b1, io_sample_pkg::OFF_DEST_LOW, 32'h5A5A_0002);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, io_sample_pkg::OFF_SUPPLY_THR, {16'h0, THR[i]});
      bus(1'b1, io_sample_pkg::OFF_COMMAND, {30'h0, i[0], 1'b1});
      n_exp++;
      expect_reports("force report");
      check(last_kind, i[0] ? 2'h3 : 2'h2, "force kind");
      check(last_dest, 64'hA5A5_0001_5A5A_0002, "destination");
      check(last_mask, {ADDS[i], 7'h0F}, "analog mask");
      check(last_supply, ADDS[i] ? SUPPLY : 16'h0, "supply");
    end
    bus(1'b0, io_sample_pkg::OFF_REPORT_INFO, 32'h0);
    check(rd, 32'h0000_0F03, "last report info");
    bus(1'b0, io_sample_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h0004_0001, "report count");
    check(n_errors, 16'h1, "no further error");
    $display("test force done");
    lines <= 15'h0008;
    n_exp++;
    expect_reports("masked edge");
    check(last_kind, io_sample_pkg::KIND_CHANGE, "change kind");
    check(last_lines, 15'h0008, "change lines");
    check(last_dest, 64'hA5A5_0001_5A5A_0002, "change destination");
    lines <= 15'h0028;
    expect_reports("unmasked edge");
    awake <= 1'b0;
    repeat (5) @(posedge clock_in);
    lines <= 15'h0020;
    repeat (5) @(posedge clock_in);
    awake <= 1'b1;
    expect_reports("edge while asleep");
    lines <= 15'h0028;
    n_exp++;
    expect_reports("edge after wake");
    $display("test change done");
    bus(1'b1, io_sample_pkg::OFF_SAMPLE_INT, 32'h32);
    n_exp++;
    wait_report(n_wait);
    check(last_kind, io_sample_pkg::KIND_PERIODIC, "periodic kind");
    check(last_lines, 15'h0028, "periodic lines");
    check(last_dest, 64'hA5A5_0001_5A5A_0002, "periodic destination");
    n_exp++;
    wait_report(n_wait);
    check(n_wait, 32'(32'h32 * MS_CYCLES), "periodic spacing");
    bus(1'b1, io_sample_pkg::OFF_SAMPLE_INT, 32'h0);
    repeat (600) @(posedge clock_in);
    expect_reports("periodic off");
    $display("test periodic done");
    end_of_test();
  end
endmodule
